// ---- bench/i2c_slave_interface_checker.sv ----
// Wire-level checks on the link between the two-wire slave and master.
// Assumes the slave is enabled with address OwnAddr before any START.
`timescale 1ns/1ns
module i2c_slave_interface_checker #(
	parameter logic [6:0] OwnAddr = 7'h2a
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset,
	// Resolved wires and the slave's enables.
	input wire logic scl,
	input wire logic sda,
	input wire logic sclDevOeN,
	input wire logic sdaDevOeN
);
	logic       sclQ;
	logic       sdaQ;
	logic       matchQ;
	logic       dirQ;
	logic       nackQ;
	logic       ignoreQ;
	logic [4:0] cnt;
	logic [7:0] sh;
	logic       rise;
	logic       fall;
	logic       start;
	logic       stop;

	// Bus events; the bus moves far slower than clk, so one flop will do.
	assign rise  = !sclQ && scl;
	assign fall  = sclQ && !scl;
	assign start = sclQ && scl && sdaQ && !sda;
	assign stop  = sclQ && scl && !sdaQ && sda;

	// Count rises since START and keep the bits as they pass.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sclQ    <= 1'b1;
			sdaQ    <= 1'b1;
			cnt     <= 5'h0;
			sh      <= 8'h0;
			matchQ  <= 1'b0;
			dirQ    <= 1'b0;
			nackQ   <= 1'b0;
			ignoreQ <= 1'b0;
		end else begin
			sclQ <= scl;
			sdaQ <= sda;
			if (start) begin
				cnt     <= 5'h0;
				ignoreQ <= 1'b0;
			end else if (rise) begin
				cnt <= (cnt == 5'h1f) ? cnt : cnt + 5'h1;
				sh  <= {sh[6:0], sda};
			end
			if (rise && cnt == 5'h8) begin
				matchQ  <= (sh[7:1] == OwnAddr);
				dirQ    <= sh[0];
				ignoreQ <= (sh[7:1] != OwnAddr);
			end
			// Acknowledge bits of the first and second data bytes.
			if (rise && (cnt == 5'h11 || cnt == 5'h1a))
				nackQ <= sda;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	a_no_start_made: assert property (
		$fell(sdaDevOeN) |-> !scl) else $error("slave pulled SDA with SCL high");
	a_stretch_low: assert property (
		$fell(sclDevOeN) |-> !scl) else $error("slave pulled SCL while high");
	a_addr_ack: assert property (
		rise && cnt == 5'h8 |-> sdaDevOeN == (sh[7:1] != OwnAddr))
		else $error("address acknowledge wrong");
	a_addr_stretch: assert property (
		fall && cnt == 5'h9 && matchQ |-> ##[1:8] !sclDevOeN)
		else $error("no stretch after address");
	a_ack_release: assert property (
		fall && cnt == 5'h9 && matchQ && !dirQ |-> ##[1:8] sdaDevOeN)
		else $error("acknowledge not released");
	a_nack_release: assert property (
		fall && (cnt == 5'h12 || cnt == 5'h1b) && matchQ && dirQ && nackQ
		|-> (sdaDevOeN && sclDevOeN) [*8]) else $error("held bus after refusal");
	a_foreign_quiet: assert property (
		ignoreQ |-> sdaDevOeN && sclDevOeN) else $error("foreign address driven");
	a_stop_release: assert property (
		stop |-> ##[1:8] (sdaDevOeN && sclDevOeN)) else $error("held after stop");

	// Main scenarios: write, read and foreign address.
	c_write: cover property (rise && cnt == 5'h8 && sh == {OwnAddr, 1'b0});
	c_read: cover property (rise && cnt == 5'h8 && sh == {OwnAddr, 1'b1});
	c_foreign: cover property (ignoreQ && stop);
endmodule

// ---- bench/tb_i2c_slave_interface.sv ----
// Self-checking bench joining the two-wire slave to the bus master.
// Assumes a 100 MHz clock and a shortened master bit time.
`timescale 1ns/1ns
`include "i2c_link_map.svh"
module tb_i2c_slave_interface;
	localparam logic [6:0] OwnAddr = 7'h2a;

	logic       clk = 1'b0;
	logic       reset;
	logic [1:0] dAddr;
	logic [1:0] hAddr;
	logic [7:0] dWd;
	logic [7:0] hWd;
	logic [7:0] dRdData;
	logic [7:0] hRdData;
	logic [7:0] s;
	logic       dWr;
	logic       dRd;
	logic       hWr;
	logic       hRd;
	logic       irqReq;
	logic [8:0] wireSh;
	int         errors = 0;
	int         numChecks = 0;
	int         irqCnt = 0;

	i2c_link_if link ();
	i2c_slave_dev i_i2c_slave_dev (.clk(clk), .reset(reset), .regAddr(dAddr),
		.wrData(dWd), .wrStb(dWr), .rdStb(dRd), .rdData(dRdData),
		.irqReq(irqReq), .link(link));
	i2c_master_host #(.HalfCycles(20)) i_i2c_master_host (.clk(clk),
		.reset(reset), .regAddr(hAddr), .wrData(hWd), .wrStb(hWr),
		.rdStb(hRd), .rdData(hRdData), .link(link));
	i2c_slave_interface_checker #(.OwnAddr(OwnAddr))
		i_i2c_slave_interface_checker (.clk(clk), .reset(reset),
		.scl(link.scl), .sda(link.sda), .sclDevOeN(link.sclDevOeN),
		.sdaDevOeN(link.sdaDevOeN));

	// Free-running system clock.
	always #5 clk = ~clk;

	// Count interrupt pulses and keep the last nine bits seen on the wire.
	// Every pulse counts, as though software enabled the interrupt at set-up.
	always @(posedge clk) begin
		if (irqReq === 1'b1)
			irqCnt++;
	end
	always @(posedge link.scl) begin
		wireSh <= {wireSh[7:0], link.sda};
	end

	task automatic end_sim();
		if (errors == 0 && numChecks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [8:0] got, exp, input string m);
		numChecks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask

	// One register access on either port; a read leaves its data in s.
	task automatic rw(input bit h, rd, input logic [1:0] a,
		input logic [7:0] d);
		@(posedge clk);
		if (h)
			{hAddr, hWd, hWr, hRd} <= {a, d, !rd, rd};
		else
			{dAddr, dWd, dWr, dRd} <= {a, d, !rd, rd};
		@(posedge clk);
		{hWr, hRd, dWr, dRd} <= 4'h0;
		@(negedge clk);
		s = h ? hRdData : dRdData;
	endtask

	// Poll the master until idle; a stuck master counts as a mismatch.
	task automatic hWait();
		for (int i = 0; i < 400; i++) begin
			rw(1, 1, `HOST_REG_STAT, 8'h0);
			if (s[`HST_BUSY] === 1'b0)
				break;
		end
		chk(s[`HST_BUSY], 1'b0, "master stuck busy");
	endtask

	task automatic cmd(input logic [2:0] c);
		rw(1, 0, `HOST_REG_CMD, {5'h0, c});
	endtask

	// Looks between edges so the enable is settled when it is judged.
	task automatic waitStretch();
		for (int i = 0; i < 3000 && link.sclDevOeN !== 1'b0; i++)
			@(negedge clk);
		chk(link.sclDevOeN, 1'b0, "no stretch");
	endtask

	task automatic hostAck(input logic exp);
		rw(1, 1, `HOST_REG_STAT, 8'h0);
		chk(s[`HST_RXACK], exp, "master saw wrong acknowledge");
	endtask

	task automatic stopBus();
		cmd(`CMD_STOP);
		hWait();
		rw(0, 1, `DEV_REG_STAT, 8'h0);
		chk(s[`ST_BUSY], 1'b0, "busy after stop");
		rw(0, 0, `DEV_REG_STAT, 8'h0);
	endtask

	// Master writes two bytes; the slave takes the first, refuses the second.
	task automatic sc_write(input logic [7:0] ctl);
		int n;
		rw(0, 0, `DEV_REG_CTRL, ctl);
		n = irqCnt;
		rw(1, 0, `HOST_REG_TXD, {OwnAddr, 1'b0});
		cmd(`CMD_START);
		hWait();
		cmd(`CMD_WRITE);
		waitStretch();
		chk(wireSh, {OwnAddr, 2'h0}, "address on wire");
		rw(0, 1, `DEV_REG_STAT, 8'h0);
		chk(s & 8'h64, 8'h60, "matched status");
		chk(9'(irqCnt - n), 9'h1, "address irq");
		rw(0, 1, `DEV_REG_DATA, 8'h0);
		hWait();
		rw(1, 0, `HOST_REG_TXD, 8'ha5);
		cmd(`CMD_WRITE);
		waitStretch();
		chk(wireSh, {8'ha5, 1'b0}, "byte on wire");
		rw(0, 1, `DEV_REG_STAT, 8'h0);
		chk(s & 8'he4, 8'ha0, "done status");
		chk(9'(irqCnt - n), 9'h2, "byte irq");
		rw(0, 0, `DEV_REG_STAT, 8'h08);
		rw(0, 1, `DEV_REG_DATA, 8'h0);
		chk(s, 8'ha5, "received byte");
		hWait();
		hostAck(1'b0);
		rw(1, 0, `HOST_REG_TXD, 8'h3c);
		cmd(`CMD_WRITE);
		waitStretch();
		chk(wireSh, {8'h3c, 1'b1}, "refusal on wire");
		rw(0, 1, `DEV_REG_DATA, 8'h0);
		chk(s, 8'h3c, "second byte");
		hWait();
		hostAck(1'b1);
		stopBus();
	endtask

	// Master reads two bytes, takes the first and refuses the second.
	task automatic sc_read();
		rw(1, 0, `HOST_REG_TXD, {OwnAddr, 1'b1});
		cmd(`CMD_START);
		hWait();
		cmd(`CMD_WRITE);
		waitStretch();
		rw(0, 1, `DEV_REG_STAT, 8'h0);
		chk(s & 8'h64, 8'h64, "read direction");
		rw(0, 0, `DEV_REG_STAT, 8'h10);
		rw(0, 1, `DEV_REG_DATA, 8'h0);
		repeat (4) @(posedge clk);
		chk(link.sclDevOeN, 1'b0, "read released transmit");
		rw(0, 0, `DEV_REG_DATA, 8'hc6);
		hWait();
		rw(1, 0, `HOST_REG_CMD, 8'h03);
		waitStretch();
		hWait();
		rw(1, 1, `HOST_REG_RXD, 8'h0);
		chk(s, 8'hc6, "byte read by master");
		chk(wireSh, {8'hc6, 1'b0}, "read byte on wire");
		rw(0, 1, `DEV_REG_STAT, 8'h0);
		chk(s & 8'h81, 8'h80, "acknowledge not recorded");
		rw(0, 0, `DEV_REG_DATA, 8'h5a);
		rw(1, 0, `HOST_REG_CMD, 8'h13);
		hWait();
		rw(1, 1, `HOST_REG_RXD, 8'h0);
		chk(s, 8'h5a, "second byte read by master");
		chk(wireSh, {8'h5a, 1'b1}, "second byte on wire");
		rw(0, 1, `DEV_REG_STAT, 8'h0);
		chk(s[`ST_RXACK], 1'b1, "refusal not recorded");
		stopBus();
	endtask

	// A foreign address: no acknowledge, no interrupt, slave stays quiet.
	task automatic sc_foreign();
		int n;
		n = irqCnt;
		rw(1, 0, `HOST_REG_TXD, {OwnAddr ^ 7'h01, 1'b0});
		cmd(`CMD_START);
		hWait();
		rw(0, 1, `DEV_REG_STAT, 8'h0);
		chk(s[`ST_BUSY], 1'b1, "busy after start");
		cmd(`CMD_WRITE);
		hWait();
		hostAck(1'b1);
		rw(0, 1, `DEV_REG_STAT, 8'h0);
		chk(s[`ST_MATCH], 1'b0, "foreign match");
		chk(9'(irqCnt - n), 9'h0, "foreign irq");
		stopBus();
	endtask

	// Main sequence; debounce settings none, one and two clocks.
	initial begin
		reset = 1'b1;
		{dAddr, dWd, dWr, dRd, hAddr, hWd, hWr, hRd} = '0;
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		rw(0, 0, `DEV_REG_ADDR, {OwnAddr, 1'b1});
		rw(0, 1, `DEV_REG_ADDR, 8'h0);
		chk(s, {OwnAddr, 1'b0}, "own address");
		sc_write(8'h01);
		sc_write(8'h03);
		sc_write(8'h05);
		sc_read();
		sc_foreign();
		sc_write(8'h01);
		end_sim();
	end

	// Cut a hang short well beyond the expected run length.
	initial begin
		#400000;
		errors++;
		end_sim();
	end
endmodule

// ---- logic/i2c_link_if.sv ----
// Open-drain two-wire link between the slave and the master.
// Each end drives a level and an active-low output enable per line.
`timescale 1ns/1ns
interface i2c_link_if;
	// Master side drive.
	logic sclHostO;
	logic sclHostOeN;
	logic sdaHostO;
	logic sdaHostOeN;
	// Slave side drive.
	logic sclDevO;
	logic sclDevOeN;
	logic sdaDevO;
	logic sdaDevOeN;
	// Resolved wire levels.
	logic scl;
	logic sda;

	// A released line floats high through the pull-up.
	assign scl = (sclHostOeN | sclHostO) & (sclDevOeN | sclDevO);
	assign sda = (sdaHostOeN | sdaHostO) & (sdaDevOeN | sdaDevO);

	modport dev (
		input  scl,
		input  sda,
		output sclDevO,
		output sclDevOeN,
		output sdaDevO,
		output sdaDevOeN
	);

	modport host (
		input  scl,
		input  sda,
		output sclHostO,
		output sclHostOeN,
		output sdaHostO,
		output sdaHostOeN
	);
endinterface

// ---- logic/i2c_link_map.svh ----
// Offsets, field positions, command codes and timing counts for the
// two-wire slave and its test-side master.
// Assumes an 8-bit register port with a 2-bit word address.
`ifndef I2C_LINK_MAP_SVH
`define I2C_LINK_MAP_SVH

// System clock period and bus timing.
`define CLK_PERIOD_NS 10
`define SCL_HALF_NS   5000
`define SCL_HALF_CYC  ((`SCL_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BYTE_BITS     4'h8

// Slave register offsets.
`define DEV_REG_CTRL 2'h0
`define DEV_REG_STAT 2'h1
`define DEV_REG_ADDR 2'h2
`define DEV_REG_DATA 2'h3

// Slave control register fields.
`define CTL_ENABLE 0
`define CTL_DB_LO  1
`define CTL_DB_HI  2

// Slave control and status register fields.
`define ST_DONE   7
`define ST_MATCH  6
`define ST_BUSY   5
`define ST_TXMODE 4
`define ST_TXACK  3
`define ST_DIR    2
`define ST_RXACK  0

// Debounce selections on the bus clock input.
`define DB_NONE 2'h0
`define DB_ONE  2'h1

// Master register offsets.
`define HOST_REG_TXD  2'h0
`define HOST_REG_CMD  2'h1
`define HOST_REG_STAT 2'h2
`define HOST_REG_RXD  2'h3

// Master command codes (bits 2:0) and the acknowledge value bit.
`define CMD_START 3'h1
`define CMD_WRITE 3'h2
`define CMD_READ  3'h3
`define CMD_STOP  3'h4
`define CMD_ACK   4

// Master status fields.
`define HST_BUSY  0
`define HST_RXACK 1

`endif

// ---- logic/i2c_link_pkg.sv ----
// Types shared by the two-wire slave and master.
// Assumes the constants of i2c_link_map.svh for widths.
package i2c_link_pkg;

	typedef enum logic [2:0] {
		D_IDLE, D_ADDR, D_AACK, D_WAIT, D_RX, D_RACK, D_TX, D_TACK
	} devState_t;

	typedef enum logic [3:0] {
		H_IDLE, H_SA, H_SH, H_SB, H_BL, H_BH, H_PA, H_PH, H_PD
	} hostState_t;

	typedef struct packed {
		logic       sclS1;
		logic       sclS2;
		logic       sdaS1;
		logic       sdaS2;
		logic [1:0] sclDb;
		logic       sclPrev;
		logic       sdaPrev;
		devState_t  state;
		logic       ackOn;
		logic [3:0] cnt;
		logic [7:0] shift;
		logic [7:0] dataReg;
		logic [7:0] ownAddr;
		logic       enable;
		logic [1:0] dbSel;
		logic       txMode;
		logic       txAck;
		logic       busy;
		logic       matched;
		logic       dir;
		logic       rxAck;
		logic       done;
		logic       sdaLow;
		logic       sclLow;
		logic       irq;
		logic [7:0] rdData;
	} dev_t;

	typedef struct packed {
		logic       sclS1;
		logic       sclS2;
		logic       sdaS1;
		logic       sdaS2;
		hostState_t state;
		logic [9:0] tmr;
		logic [3:0] bitCnt;
		logic [7:0] txByte;
		logic [7:0] shift;
		logic       ackVal;
		logic       rdMode;
		logic       nxtLow;
		logic       sclDrv;
		logic       sdaDrv;
		logic       rxAck;
		logic [7:0] rxData;
		logic [7:0] rdData;
	} host_t;

endpackage

// ---- logic/i2c_master_host.sv ----
// Two-wire bus master driven by commands through a register port.
// Assumes one command at a time; commands given while busy are dropped.
`timescale 1ns/1ns
`include "i2c_link_map.svh"

module i2c_master_host #(
	parameter int unsigned HalfCycles = `SCL_HALF_CYC
) (
	// Clock and reset.
	input  wire logic       clk,
	input  wire logic       reset,
	// Register port.
	input  wire logic [1:0] regAddr,
	input  wire logic [7:0] wrData,
	input  wire logic       wrStb,
	input  wire logic       rdStb,
	output logic      [7:0] rdData,
	// Two-wire link.
	i2c_link_if.host        link
);

	if (HalfCycles < 4 || HalfCycles > 1023) begin : badHalf
		$error("HalfCycles must lie between 4 and 1023");
	end

	localparam logic [9:0] HalfLd = 10'(HalfCycles);
	localparam logic [9:0] QuarterLd = 10'(HalfCycles / 2);

	i2c_link_pkg::host_t q_q;
	i2c_link_pkg::host_t q_d;
	logic                idle;

	assign idle = (q_q.state == i2c_link_pkg::H_IDLE);

	// Next state of the master.
	always_comb begin
		q_d       = q_q;
		q_d.sclS1 = link.scl;
		q_d.sclS2 = q_q.sclS1;
		q_d.sdaS1 = link.sda;
		q_d.sdaS2 = q_q.sdaS1;
		if (q_q.tmr != 10'h000) begin
			q_d.tmr = q_q.tmr - 10'h001;
		end

		if (rdStb) begin
			case (regAddr)
				`HOST_REG_TXD:  q_d.rdData = q_q.txByte;
				`HOST_REG_STAT: q_d.rdData = {6'h00, q_q.rxAck, ~idle};
				`HOST_REG_RXD:  q_d.rdData = q_q.rxData;
				default:        q_d.rdData = 8'h00;
			endcase
		end

		if (wrStb && regAddr == `HOST_REG_TXD) begin
			q_d.txByte = wrData;
		end

		case (q_q.state)
			i2c_link_pkg::H_IDLE: begin
				if (wrStb && regAddr == `HOST_REG_CMD) begin
					q_d.tmr    = HalfLd;
					q_d.bitCnt = 4'h0;
					q_d.shift  = q_q.txByte;
					q_d.rdMode = (wrData[2:0] == `CMD_READ);
					q_d.ackVal = wrData[`CMD_ACK];
					q_d.nxtLow = (wrData[2:0] == `CMD_WRITE) &
						~q_q.txByte[7];
					case (wrData[2:0])
						`CMD_START: q_d.state = i2c_link_pkg::H_SA;
						`CMD_WRITE: q_d.state = i2c_link_pkg::H_BL;
						`CMD_READ:  q_d.state = i2c_link_pkg::H_BL;
						`CMD_STOP:  q_d.state = i2c_link_pkg::H_PA;
						default:    q_d.state = i2c_link_pkg::H_IDLE;
					endcase
				end
			end
			// Release SDA first so a repeated start works from SCL low.
			i2c_link_pkg::H_SA: begin
				q_d.sdaDrv = 1'b0;
				if (q_q.tmr == 10'h000) begin
					q_d.sclDrv = 1'b0;
					q_d.tmr    = HalfLd;
					q_d.state  = i2c_link_pkg::H_SH;
				end
			end
			i2c_link_pkg::H_SH: begin
				if (!q_q.sclS2) begin
					q_d.tmr = HalfLd;
				end else if (q_q.tmr == 10'h000) begin
					q_d.sdaDrv = 1'b1;
					q_d.tmr    = HalfLd;
					q_d.state  = i2c_link_pkg::H_SB;
				end
			end
			i2c_link_pkg::H_SB: begin
				if (q_q.tmr == 10'h000) begin
					q_d.sclDrv = 1'b1;
					q_d.state  = i2c_link_pkg::H_IDLE;
				end
			end
			// SDA moves mid-low so debounced slaves see no false edge.
			i2c_link_pkg::H_BL: begin
				q_d.sclDrv = 1'b1;
				if (q_q.tmr == QuarterLd) begin
					q_d.sdaDrv = q_q.nxtLow;
				end
				if (q_q.tmr == 10'h000) begin
					q_d.sclDrv = 1'b0;
					q_d.tmr    = HalfLd;
					q_d.state  = i2c_link_pkg::H_BH;
				end
			end
			// A slave holding SCL low restarts the high time.
			i2c_link_pkg::H_BH: begin
				if (!q_q.sclS2) begin
					q_d.tmr = HalfLd;
				end else if (q_q.tmr == 10'h000) begin
					q_d.sclDrv = 1'b1;
					q_d.tmr    = HalfLd;
					q_d.bitCnt = q_q.bitCnt + 4'h1;
					if (q_q.bitCnt == `BYTE_BITS) begin
						if (q_q.rdMode) begin
							q_d.rxData = q_q.shift;
						end else begin
							q_d.rxAck = q_q.sdaS2;
						end
						q_d.state = i2c_link_pkg::H_IDLE;
					end else begin
						q_d.shift = {q_q.shift[6:0], q_q.sdaS2};
						if (q_q.bitCnt == `BYTE_BITS - 4'h1) begin
							q_d.nxtLow = q_q.rdMode & ~q_q.ackVal;
						end else begin
							q_d.nxtLow = ~q_q.rdMode & ~q_q.shift[6];
						end
						q_d.state = i2c_link_pkg::H_BL;
					end
				end
			end
			i2c_link_pkg::H_PA: begin
				q_d.sclDrv = 1'b1;
				if (q_q.tmr == QuarterLd) begin
					q_d.sdaDrv = 1'b1;
				end
				if (q_q.tmr == 10'h000) begin
					q_d.sclDrv = 1'b0;
					q_d.tmr    = HalfLd;
					q_d.state  = i2c_link_pkg::H_PH;
				end
			end
			i2c_link_pkg::H_PH: begin
				if (!q_q.sclS2) begin
					q_d.tmr = HalfLd;
				end else if (q_q.tmr == 10'h000) begin
					q_d.sdaDrv = 1'b0;
					q_d.tmr    = HalfLd;
					q_d.state  = i2c_link_pkg::H_PD;
				end
			end
			i2c_link_pkg::H_PD: begin
				if (q_q.tmr == 10'h000) begin
					q_d.state = i2c_link_pkg::H_IDLE;
				end
			end
			default: q_d.state = i2c_link_pkg::H_IDLE;
		endcase
	end

	// All state in one register; reset releases both lines.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			q_q <= '0;
		end else begin
			q_q <= q_d;
		end
	end

	assign link.sclHostO   = 1'b0;
	assign link.sclHostOeN = ~q_q.sclDrv;
	assign link.sdaHostO   = 1'b0;
	assign link.sdaHostOeN = ~q_q.sdaDrv;
	assign rdData          = q_q.rdData;

endmodule

// ---- logic/i2c_slave_dev.sv ----
// Slave-only two-wire serial interface with its register port.
// Assumes the link arrives unsynchronised and that software services
// each stretch by reading or writing the data register.
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ns
`include "i2c_link_map.svh"

// Notes on behaviour
// - START sets the bus busy flag.
// - START is SDA falling while SCL high.
// - Only the master makes START; never us.
// - First seven bits compared with own address.
// - Eighth bit stored as direction bit.
// - Matching address acknowledged low on ninth bit.
// - Matching address sets address matched flag.
// - Interrupt on match or byte completion.
// - Receive match stretches SCL until data read.
// - Transmit match waits for software data write.
// - Direction one means we transmit, zero receive.
// - Software sets transmit mode from direction bit.
// - Bytes are eight bits, MSB first.
// - Receiver acknowledges low after eight bits.
// - Receiving, drive transmit acknowledge bit on ninth.
// - Transmitting, record master acknowledge; none releases.
// - Master ends with STOP when not acknowledged.
// - Received byte lands in the data register.
// - Software enables the serial interrupt at setup; irqReq here has no enable bit and always pulses.
// - STOP clears the bus busy flag.
// - Done flag low during byte, high after.
// - Own address sits in bits seven to one.
// - SCL debounce of one or two clocks.
module i2c_slave_dev (
	// Clock and reset.
	input  wire logic       clk,
	input  wire logic       reset,
	// Register port.
	input  wire logic [1:0] regAddr,
	input  wire logic [7:0] wrData,
	input  wire logic       wrStb,
	input  wire logic       rdStb,
	output logic      [7:0] rdData,
	// Interrupt request, one cycle per event.
	output logic            irqReq,
	// Two-wire link.
	i2c_link_if.dev         link
);

	i2c_link_pkg::dev_t q_q;
	i2c_link_pkg::dev_t q_d;

	logic sclIn;
	logic sdaIn;
	logic sclRise;
	logic sclFall;
	logic startSeen;
	logic stopSeen;

	// Gathers the control and status bits into one readable byte.
	function automatic logic [7:0] statByte(input i2c_link_pkg::dev_t s);
		logic [7:0] b;
		b = 8'h00;
		b[`ST_DONE]   = s.done;
		b[`ST_MATCH]  = s.matched;
		b[`ST_BUSY]   = s.busy;
		b[`ST_TXMODE] = s.txMode;
		b[`ST_TXACK]  = s.txAck;
		b[`ST_DIR]    = s.dir;
		b[`ST_RXACK]  = s.rxAck;
		return b;
	endfunction

	// Debounce taps follow the second synchroniser stage only.
	always_comb begin
		case (q_q.dbSel)
			`DB_NONE: sclIn = q_q.sclS2;
			`DB_ONE:  sclIn = q_q.sclDb[0];
			default:  sclIn = q_q.sclDb[1];
		endcase
		sdaIn     = q_q.sdaS2;
		sclRise   = sclIn & ~q_q.sclPrev;
		sclFall   = ~sclIn & q_q.sclPrev;
		startSeen = sclIn & q_q.sclPrev & q_q.sdaPrev & ~sdaIn;
		stopSeen  = sclIn & q_q.sclPrev & ~q_q.sdaPrev & sdaIn;
	end

	// Next state: synchronisers, register port, then the bus engine.
	always_comb begin
		q_d       = q_q;
		q_d.irq   = 1'b0;
		q_d.sclS1 = link.scl;
		q_d.sclS2 = q_q.sclS1;
		q_d.sdaS1 = link.sda;
		q_d.sdaS2 = q_q.sdaS1;
		q_d.sclDb = {q_q.sclDb[0], q_q.sclS2};
		q_d.sclPrev = sclIn;
		q_d.sdaPrev = sdaIn;

		// Register reads answer in the following cycle.
		if (rdStb) begin
			case (regAddr)
				`DEV_REG_CTRL: q_d.rdData = {5'h00, q_q.dbSel, q_q.enable};
				`DEV_REG_STAT: q_d.rdData = statByte(q_q);
				`DEV_REG_ADDR: q_d.rdData = {q_q.ownAddr[7:1], 1'b0};
				default:       q_d.rdData = q_q.dataReg;
			endcase
		end

		// Register writes; status writes touch only software bits.
		if (wrStb) begin
			case (regAddr)
				`DEV_REG_CTRL: begin
					q_d.enable = wrData[`CTL_ENABLE];
					q_d.dbSel  = wrData[`CTL_DB_HI:`CTL_DB_LO];
				end
				`DEV_REG_STAT: begin
					q_d.txMode = wrData[`ST_TXMODE];
					q_d.txAck  = wrData[`ST_TXACK];
				end
				`DEV_REG_ADDR: q_d.ownAddr = wrData;
				default:       q_d.dataReg = wrData;
			endcase
		end

		// The engine never drives SDA low while SCL is high unless
		// acknowledging or sending data, so it cannot form a START.
		if (!q_q.enable) begin
			q_d.state  = i2c_link_pkg::D_IDLE;
			q_d.busy   = 1'b0;
			q_d.sdaLow = 1'b0;
			q_d.sclLow = 1'b0;
		end else if (startSeen) begin
			q_d.busy   = 1'b1;
			q_d.state  = i2c_link_pkg::D_ADDR;
			q_d.cnt    = 4'h0;
			q_d.ackOn  = 1'b0;
			q_d.sdaLow = 1'b0;
			q_d.sclLow = 1'b0;
		end else if (stopSeen) begin
			q_d.busy   = 1'b0;
			q_d.state  = i2c_link_pkg::D_IDLE;
			q_d.sdaLow = 1'b0;
			q_d.sclLow = 1'b0;
		end else begin
			case (q_q.state)
				i2c_link_pkg::D_ADDR: begin
					if (sclRise) begin
						q_d.shift = {q_q.shift[6:0], sdaIn};
						q_d.cnt   = q_q.cnt + 4'h1;
						if (q_q.cnt == `BYTE_BITS - 4'h1) begin
							// Old shift holds the seven address bits.
							if (q_q.shift[6:0] == q_q.ownAddr[7:1]) begin
								q_d.matched = 1'b1;
								q_d.dir     = sdaIn;
								q_d.irq     = 1'b1;
								q_d.ackOn   = 1'b0;
								q_d.state   = i2c_link_pkg::D_AACK;
							end else begin
								q_d.state = i2c_link_pkg::D_IDLE;
							end
						end
					end
				end
				i2c_link_pkg::D_AACK: begin
					if (sclFall) begin
						if (!q_q.ackOn) begin
							q_d.sdaLow = 1'b1;
							q_d.ackOn  = 1'b1;
						end else begin
							// Hold the clock until software picks a mode.
							q_d.sdaLow = 1'b0;
							q_d.sclLow = 1'b1;
							q_d.state  = i2c_link_pkg::D_WAIT;
						end
					end
				end
				i2c_link_pkg::D_RX: begin
					if (sclRise) begin
						q_d.shift   = {q_q.shift[6:0], sdaIn};
						q_d.cnt     = q_q.cnt + 4'h1;
						q_d.matched = 1'b0;
						q_d.done    = 1'b0;
						if (q_q.cnt == `BYTE_BITS - 4'h1) begin
							q_d.dataReg = {q_q.shift[6:0], sdaIn};
							q_d.done    = 1'b1;
							q_d.irq     = 1'b1;
							q_d.ackOn   = 1'b0;
							q_d.state   = i2c_link_pkg::D_RACK;
						end
					end
				end
				i2c_link_pkg::D_RACK: begin
					if (sclFall) begin
						if (!q_q.ackOn) begin
							q_d.sdaLow = ~q_q.txAck;
							q_d.ackOn  = 1'b1;
						end else begin
							q_d.sdaLow = 1'b0;
							q_d.sclLow = 1'b1;
							q_d.state  = i2c_link_pkg::D_WAIT;
						end
					end
				end
				i2c_link_pkg::D_TX: begin
					if (sclRise) begin
						q_d.cnt     = q_q.cnt + 4'h1;
						q_d.matched = 1'b0;
						q_d.done    = 1'b0;
					end
					if (sclFall) begin
						if (q_q.cnt == `BYTE_BITS) begin
							q_d.sdaLow = 1'b0;
							q_d.state  = i2c_link_pkg::D_TACK;
						end else begin
							q_d.sdaLow = ~q_q.shift[~q_q.cnt[2:0]];
						end
					end
				end
				i2c_link_pkg::D_TACK: begin
					if (sclRise) begin
						q_d.rxAck = sdaIn;
						q_d.done  = 1'b1;
						q_d.irq   = 1'b1;
					end
					if (sclFall) begin
						// Without an acknowledge SDA stays released.
						if (!q_q.rxAck) begin
							q_d.sclLow = 1'b1;
							q_d.state  = i2c_link_pkg::D_WAIT;
						end else begin
							q_d.state = i2c_link_pkg::D_IDLE;
						end
					end
				end
				i2c_link_pkg::D_WAIT: begin
					// Software service releases the stretched clock.
					if (rdStb && regAddr == `DEV_REG_DATA && !q_q.txMode) begin
						q_d.sclLow = 1'b0;
						q_d.cnt    = 4'h0;
						q_d.state  = i2c_link_pkg::D_RX;
					end else if (wrStb && regAddr == `DEV_REG_DATA &&
							q_q.txMode) begin
						q_d.shift  = wrData;
						q_d.sdaLow = ~wrData[7];
						q_d.sclLow = 1'b0;
						q_d.cnt    = 4'h0;
						q_d.state  = i2c_link_pkg::D_TX;
					end
				end
				default: begin
					q_d.sdaLow = 1'b0;
					q_d.sclLow = 1'b0;
				end
			endcase
		end
	end

	// All state in one register; reset gives released lines.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			q_q <= '0;
		end else begin
			q_q <= q_d;
		end
	end

	// Open-drain drive: enable goes low only to pull a line low.
	assign link.sclDevO   = 1'b0;
	assign link.sclDevOeN = ~q_q.sclLow;
	assign link.sdaDevO   = 1'b0;
	assign link.sdaDevOeN = ~q_q.sdaLow;
	assign rdData         = q_q.rdData;
	assign irqReq         = q_q.irq;

endmodule
